// file: core/gsrm_params.svh
// Purpose: constants of the gas sensor register bank
// Assumes: included by the package and the bench
// Notes: addresses are zero-based protocol addresses
`ifndef GSRM_PARAMS_SVH
`define GSRM_PARAMS_SVH

`define GSRM_FC_READ_HOLD 8'h03
`define GSRM_FC_MEI 8'h2b
`define GSRM_MEI_DEV_ID 8'h0e
`define GSRM_FC_EXC_BIT 8'h80

`define GSRM_EXC_ILL_FUNC 8'h01
`define GSRM_EXC_ILL_ADDR 8'h02
`define GSRM_EXC_ILL_VALUE 8'h03

`define GSRM_QTY_MAX 16'h007d

`define GSRM_A_GAS_F 16'h0000
`define GSRM_A_TEMP_F 16'h0004
`define GSRM_A_GAS_I 16'h0100
`define GSRM_A_TEMP_I 16'h0102
`define GSRM_A_HEALTH 16'h0200
`define GSRM_A_ERR 16'h0201
`define GSRM_A_TEMP_COND 16'h0206
`define GSRM_A_GAS_COND 16'h0207

`define GSRM_QNAN 32'h7fc00000
`define GSRM_INT_NA 16'h8000
`define GSRM_INT_POS_MAX 16'h7ffe
`define GSRM_INT_NEG_MIN 16'h8002

`define GSRM_COND_OK 16'h0000
`define GSRM_COND_UNDER 16'h0004
`define GSRM_COND_OVER 16'h0008
`define GSRM_COND_FAIL 16'h0080
`define GSRM_COND_NOT_READY 16'h0100

`endif

// file: core/gsrm_pkg.sv
// Purpose: types of the gas sensor register bank
// Assumes: gsrm_params.svh holds the numbers
// Notes: request and answer travel as packed structs
`include "gsrm_params.svh"

package gsrm_pkg;

    typedef struct packed {
        logic under;
        logic over;
        logic fail;
        logic not_ready;
    } gsrm_cond_s;

    typedef struct packed {
        logic [31:0] gas_float;
        logic [31:0] temp_float;
        logic [15:0] gas_int;
        logic [15:0] temp_tenths;
        logic gas_avail;
        logic temp_avail;
    } gsrm_meas_s;

    typedef struct packed {
        logic [15:0] health;
        logic [31:0] err_code;
        gsrm_cond_s temp_cond;
        gsrm_cond_s gas_cond;
    } gsrm_stat_s;

    typedef struct packed {
        logic [7:0] func;
        logic [7:0] mei;
        logic [15:0] addr;
        logic [15:0] qty;
    } gsrm_req_s;

    typedef enum logic [1:0] {
        GSRM_RSP_DATA = 2'b00,
        GSRM_RSP_EXC = 2'b01,
        GSRM_RSP_IDENT = 2'b10
    } gsrm_rsp_kind_e;

    typedef struct packed {
        logic valid;
        gsrm_rsp_kind_e kind;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] word;
        logic last;
        logic [7:0] exc_code;
    } gsrm_rsp_s;

    typedef enum logic [1:0] {
        GSRM_ST_IDLE = 2'b00,
        GSRM_ST_DECODE = 2'b01,
        GSRM_ST_CHECK = 2'b10,
        GSRM_ST_STREAM = 2'b11
    } gsrm_state_e;

    // failure outranks not-ready, which outranks range flags
    function automatic logic [15:0] gsrm_cond_code(input gsrm_cond_s c);
        if (c.fail) begin
            return `GSRM_COND_FAIL;
        end else if (c.not_ready) begin
            return `GSRM_COND_NOT_READY;
        end else if (c.over) begin
            return `GSRM_COND_OVER;
        end else if (c.under) begin
            return `GSRM_COND_UNDER;
        end
        return `GSRM_COND_OK;
    endfunction : gsrm_cond_code

endpackage : gsrm_pkg

// file: core/gsrm_hold.sv
// Purpose: snapshot register loaded on one strobe
// Assumes: din is stable in the load cycle
// Notes: one load takes every bit of one sample
module gsrm_hold #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] hold_q, hold_d;

    always_comb begin
        hold_d = load ? din : hold_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hold_q <= '0;
        end else begin
            hold_q <= hold_d;
        end
    end

    assign dout = hold_q;
endmodule : gsrm_hold

// file: core/gsrm_bank.sv
// Purpose: read-only register bank behind a decoded request port
// Assumes: request and sample inputs come from ref_clk logic
// Notes: one answer word per cycle, exceptions before any data
// Function
// - read holding registers and device identification only
// - float and integer forms at distinct addresses
// - floats are single-precision binary32
// - float low word first, high word next
// - codes 0000..7ffe mean 0..32766
// - codes 8002..ffff are negative two's complement
// - code 8000 means value not available
// - protocol address is register number minus one
// - missing data reads NaN or 8000, no exception
// - exception only outside implemented ranges
// - gas and temperature at their fixed addresses
// - integer temperature is tenths of a degree
// - device health reads zero when healthy
// - 32-bit error code at 0201
// - condition codes ok, under, over, fail, not-ready
// - not-ready never on temperature condition
module gsrm_bank
    import gsrm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic req_valid,
    input gsrm_req_s req,
    output logic req_ready,
    input gsrm_meas_s meas,
    input gsrm_stat_s stat,
    output gsrm_rsp_s rsp
);
    gsrm_state_e state_q, state_d;
    gsrm_req_s cur_q, cur_d;
    logic [16:0] cursor_q, cursor_d;
    logic [15:0] count_q, count_d;
    gsrm_rsp_s rsp_q, rsp_d;
    logic ready_q, ready_d;
    logic accept;
    gsrm_meas_s snap_m;
    gsrm_stat_s snap_s;
    logic hit;
    logic [15:0] word;

    assign accept = req_valid & ready_q;

    // sampled once per request so multi-word values never tear
    gsrm_hold #(
        .WIDTH($bits(gsrm_meas_s))
    ) u_hold_meas (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(accept),
        .din(meas),
        .dout(snap_m)
    );

    gsrm_hold #(
        .WIDTH($bits(gsrm_stat_s))
    ) u_hold_stat (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(accept),
        .din(stat),
        .dout(snap_s)
    );

    // 7fff and 8001 are undefined codes, so they fold to the limits
    function automatic logic [15:0] int_code(input logic avail,
                                             input logic [15:0] v);
        if (!avail) begin
            return `GSRM_INT_NA;
        end else if (v == `GSRM_INT_POS_MAX + 16'h0001) begin
            return `GSRM_INT_POS_MAX;
        end else if (v == `GSRM_INT_NA || v == `GSRM_INT_NA + 16'h0001) begin
            return `GSRM_INT_NEG_MIN;
        end
        return v;
    endfunction : int_code

    // addresses here are already zero-based
    always_comb begin
        hit = 1'b1;
        word = 16'h0000;
        if (cursor_q[16]) begin
            hit = 1'b0;
        end else begin
            unique case (cursor_q[15:0])
                `GSRM_A_GAS_F: begin
                    word = snap_m.gas_avail ? snap_m.gas_float[15:0]
                                            : 16'(`GSRM_QNAN & 32'h0000ffff);
                end
                `GSRM_A_GAS_F + 16'h0001: begin
                    word = snap_m.gas_avail ? snap_m.gas_float[31:16]
                                            : 16'(`GSRM_QNAN >> 16);
                end
                `GSRM_A_TEMP_F: begin
                    word = snap_m.temp_avail ? snap_m.temp_float[15:0]
                                             : 16'(`GSRM_QNAN & 32'h0000ffff);
                end
                `GSRM_A_TEMP_F + 16'h0001: begin
                    word = snap_m.temp_avail ? snap_m.temp_float[31:16]
                                             : 16'(`GSRM_QNAN >> 16);
                end
                `GSRM_A_GAS_I: begin
                    word = int_code(snap_m.gas_avail, snap_m.gas_int);
                end
                `GSRM_A_TEMP_I: begin
                    word = int_code(snap_m.temp_avail, snap_m.temp_tenths);
                end
                `GSRM_A_HEALTH: begin
                    word = snap_s.health;
                end
                `GSRM_A_ERR: begin
                    word = snap_s.err_code[15:0];
                end
                `GSRM_A_ERR + 16'h0001: begin
                    word = snap_s.err_code[31:16];
                end
                `GSRM_A_TEMP_COND: begin
                    word = gsrm_cond_code(snap_s.temp_cond) &
                           ~`GSRM_COND_NOT_READY;
                end
                `GSRM_A_GAS_COND: begin
                    word = gsrm_cond_code(snap_s.gas_cond);
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        cursor_d = cursor_q;
        count_d = count_q;
        rsp_d = '0;
        rsp_d.kind = GSRM_RSP_DATA;
        unique case (state_q)
            GSRM_ST_IDLE: begin
                if (accept) begin
                    cur_d = req;
                    state_d = GSRM_ST_DECODE;
                end
            end
            GSRM_ST_DECODE: begin
                cursor_d = {1'b0, cur_q.addr};
                count_d = cur_q.qty;
                state_d = GSRM_ST_IDLE;
                rsp_d.valid = 1'b1;
                rsp_d.func = cur_q.func;
                rsp_d.last = 1'b1;
                if (cur_q.func == `GSRM_FC_READ_HOLD) begin
                    if (cur_q.qty == 16'h0000 ||
                        cur_q.qty > `GSRM_QTY_MAX) begin
                        rsp_d.kind = GSRM_RSP_EXC;
                        rsp_d.func = cur_q.func | `GSRM_FC_EXC_BIT;
                        rsp_d.exc_code = `GSRM_EXC_ILL_VALUE;
                    end else begin
                        rsp_d = '0;
                        state_d = GSRM_ST_CHECK;
                    end
                end else if (cur_q.func == `GSRM_FC_MEI &&
                             cur_q.mei == `GSRM_MEI_DEV_ID) begin
                    rsp_d.kind = GSRM_RSP_IDENT;
                end else begin
                    rsp_d.kind = GSRM_RSP_EXC;
                    rsp_d.func = cur_q.func | `GSRM_FC_EXC_BIT;
                    rsp_d.exc_code = `GSRM_EXC_ILL_FUNC;
                end
            end
            GSRM_ST_CHECK: begin
                // whole span is checked first so no data precedes a fault
                if (!hit) begin
                    state_d = GSRM_ST_IDLE;
                    rsp_d.valid = 1'b1;
                    rsp_d.kind = GSRM_RSP_EXC;
                    rsp_d.func = cur_q.func | `GSRM_FC_EXC_BIT;
                    rsp_d.exc_code = `GSRM_EXC_ILL_ADDR;
                    rsp_d.last = 1'b1;
                end else if (count_q == 16'h0001) begin
                    cursor_d = {1'b0, cur_q.addr};
                    count_d = cur_q.qty;
                    state_d = GSRM_ST_STREAM;
                end else begin
                    cursor_d = cursor_q + 17'h00001;
                    count_d = count_q - 16'h0001;
                end
            end
            GSRM_ST_STREAM: begin
                rsp_d.valid = 1'b1;
                rsp_d.func = cur_q.func;
                rsp_d.addr = cursor_q[15:0];
                rsp_d.word = word;
                rsp_d.last = (count_q == 16'h0001);
                cursor_d = cursor_q + 17'h00001;
                count_d = count_q - 16'h0001;
                if (count_q == 16'h0001) begin
                    state_d = GSRM_ST_IDLE;
                end
            end
        endcase
        ready_d = (state_d == GSRM_ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= GSRM_ST_IDLE;
            cur_q <= '0;
            cursor_q <= 17'h00000;
            count_q <= 16'h0000;
            rsp_q <= '0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            cursor_q <= cursor_d;
            count_q <= count_d;
            rsp_q <= rsp_d;
            ready_q <= ready_d;
        end
    end

    assign req_ready = ready_q;
    assign rsp = rsp_q;

    AST_ONLY_KNOWN_FUNCS: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind != GSRM_RSP_EXC) |->
        (rsp_q.func == `GSRM_FC_READ_HOLD || rsp_q.func == `GSRM_FC_MEI))
        else $error("non-exception answer to an unsupported function");

    AST_WRITE_REFUSED: assert property (
        @(posedge ref_clk) disable iff (srst)
        (accept && req.func == 8'h10) |->
        ##2 (rsp_q.valid && rsp_q.kind == GSRM_RSP_EXC &&
             rsp_q.exc_code == `GSRM_EXC_ILL_FUNC))
        else $error("write function not refused two cycles later");

    AST_LOW_WORD_FIRST: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_GAS_F && snap_m.gas_avail && !rsp_q.last)
        |-> rsp_q.word == snap_m.gas_float[15:0] ##1
            (rsp_q.valid && rsp_q.word == snap_m.gas_float[31:16]))
        else $error("float words not low first from one sample");

    AST_NAN_WHEN_MISSING: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_TEMP_F + 16'h0001 && !snap_m.temp_avail)
        |-> rsp_q.word == 16'h7fc0)
        else $error("missing temperature float is not a quiet NaN");

    AST_INT_NA_RESERVED: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_GAS_I)
        |-> ((rsp_q.word == `GSRM_INT_NA) == !snap_m.gas_avail))
        else $error("8000 code not tied to missing gas value");

    AST_INT_POSITIVE: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.addr == `GSRM_A_TEMP_I &&
         rsp_q.kind == GSRM_RSP_DATA && snap_m.temp_avail &&
         snap_m.temp_tenths <= `GSRM_INT_POS_MAX)
        |-> rsp_q.word == snap_m.temp_tenths)
        else $error("non-negative temperature code altered");

    AST_INT_NEGATIVE: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.addr == `GSRM_A_GAS_I &&
         rsp_q.kind == GSRM_RSP_DATA && snap_m.gas_avail &&
         snap_m.gas_int[15])
        |-> rsp_q.word >= `GSRM_INT_NEG_MIN)
        else $error("negative gas code outside 8002..ffff");

    AST_TEMP_NOT_READY_CLEAR: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_TEMP_COND)
        |-> (rsp_q.word != `GSRM_COND_NOT_READY &&
             (rsp_q.word == 16'h0000) == (snap_s.temp_cond == 4'h0 ||
                                          snap_s.temp_cond == 4'h1)))
        else $error("temperature condition shows not-ready");

    AST_HEALTH_PASS: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_HEALTH) |-> rsp_q.word == snap_s.health)
        else $error("device health word differs from sample");

    AST_MAPPED_NO_EXC: assert property (
        @(posedge ref_clk) disable iff (srst)
        (accept && req.func == `GSRM_FC_READ_HOLD &&
         req.addr == `GSRM_A_GAS_F && req.qty == 16'h0002)
        |-> ##5 (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA)
            ##1 (rsp_q.valid && rsp_q.last))
        else $error("read of mapped float did not answer with data");

    AST_DATA_RUN_UNBROKEN: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA && !rsp_q.last) |=>
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA))
        else $error("data answer broken before its last word");

    AST_EXC_CARRIES_NO_DATA: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_EXC) |->
        (rsp_q.last && rsp_q.word == 16'h0000 && rsp_q.addr == 16'h0000 &&
         rsp_q.func[7]))
        else $error("exception answer carries data or lacks last");

    AST_TEMP_FLOAT_HIGH: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_TEMP_F + 16'h0001 && snap_m.temp_avail)
        |-> rsp_q.word == snap_m.temp_float[31:16])
        else $error("temperature float high word misplaced");

    AST_ERR_HIGH_WORD: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_ERR + 16'h0001)
        |-> rsp_q.word == snap_s.err_code[31:16])
        else $error("error code high word misplaced");

    AST_GAS_COND_CODES: assert property (
        @(posedge ref_clk) disable iff (srst)
        (rsp_q.valid && rsp_q.kind == GSRM_RSP_DATA &&
         rsp_q.addr == `GSRM_A_GAS_COND)
        |-> rsp_q.word inside {`GSRM_COND_OK, `GSRM_COND_UNDER,
            `GSRM_COND_OVER, `GSRM_COND_FAIL, `GSRM_COND_NOT_READY})
        else $error("gas condition word is not a defined code");

    // the sample loads at accept, so it settles two edges before the first check
    AST_SNAP_HELD: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!ready_q && !$past(ready_q)) |->
        ($stable(snap_m) && $stable(snap_s)))
        else $error("sample changed while an answer was pending");
endmodule : gsrm_bank

// file: tb/gsrm_master_model.sv
// Purpose: polling master in front of the register bank
// Assumes: bank samples on the rising edge, model moves on the falling edge
// Notes: one call sends one request and gathers its whole answer
module gsrm_master_model
    import gsrm_pkg::*;
(
    input wire logic ref_clk,
    output logic req_valid,
    output gsrm_req_s req,
    input wire logic req_ready,
    input gsrm_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    gsrm_rsp_s got_q[$];
    int first_lat;
    event taken;

    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    task automatic transact(input gsrm_req_s r);
        int n;
        got_q.delete();
        first_lat = -1;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = r;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        -> taken;
        @(negedge ref_clk);
        req_valid = 1'b0;
        // a released request must not keep showing its last value
        req = ~r;
        for (n = 1; n < 400; n++) begin
            if (rsp.valid === 1'b1) begin
                if (first_lat < 0) begin
                    first_lat = n;
                end
                got_q.push_back(rsp);
                if (rsp.last === 1'b1) begin
                    break;
                end
            end
            @(negedge ref_clk);
        end
    endtask : transact
endmodule : gsrm_master_model

// file: tb/gas_sensor_modbus_register_map_tb_top.sv
// Purpose: self-checking bench of the read-only register bank
// Assumes: inputs change on the falling edge only
// Notes: expected words come from the tables below, not from the bank
`include "gsrm_params.svh"

`define GSRM_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("unexpected %s: expected %h seen %h", nm, e, g); \
    errors++; end end

module gas_sensor_modbus_register_map_tb_top
    import gsrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk;
    logic srst;
    logic req_valid;
    logic req_ready;
    gsrm_req_s req;
    gsrm_meas_s meas;
    gsrm_stat_s stat;
    gsrm_rsp_s rsp;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    gsrm_bank u_gsrm_bank (.ref_clk(ref_clk), .srst(srst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .meas(meas), .stat(stat), .rsp(rsp));

    gsrm_master_model u_mst (.ref_clk(ref_clk), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp(rsp));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // the whole run needs about two hundred and fifty cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            complete_run();
        end
    end

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] q,
            input logic [15:0] w0, input logic [15:0] w1,
            input logic [15:0] w2);
        logic [15:0] w [3];
        w = '{w0, w1, w2};
        u_mst.transact('{8'h03, 8'h00, a, q});
        `GSRM_CHK("words", int'(q), u_mst.got_q.size())
        `GSRM_CHK("first word", int'(q) + 3, u_mst.first_lat)
        for (int i = 0; i < u_mst.got_q.size() && i < 3; i++) begin
            `GSRM_CHK("kind", GSRM_RSP_DATA, u_mst.got_q[i].kind)
            `GSRM_CHK("addr", a + 16'(i), u_mst.got_q[i].addr)
            `GSRM_CHK("word", w[i], u_mst.got_q[i].word)
        end
    endtask : rd_chk

    task automatic exc_chk(input logic [7:0] f, input logic [7:0] m,
            input logic [15:0] a, input logic [15:0] q,
            input gsrm_rsp_kind_e k, input logic [7:0] rf,
            input logic [7:0] code, input int lat);
        u_mst.transact('{f, m, a, q});
        `GSRM_CHK("answers", 1, u_mst.got_q.size())
        `GSRM_CHK("latency", lat, u_mst.first_lat)
        if (u_mst.got_q.size() > 0) begin
            `GSRM_CHK("kind", k, u_mst.got_q[0].kind)
            `GSRM_CHK("func", rf, u_mst.got_q[0].func)
            `GSRM_CHK("last", 1'b1, u_mst.got_q[0].last)
            if (k == GSRM_RSP_EXC) begin
                `GSRM_CHK("code", code, u_mst.got_q[0].exc_code)
            end
        end
    endtask : exc_chk

    task automatic t_float();
        meas = '{32'h4417e63a, 32'h41b4cccd, 16'h025f, 16'h00e2, 1'b1, 1'b1};
        rd_chk(16'h0000, 16'h0002, 16'he63a, 16'h4417, 16'h0000);
        `GSRM_CHK("float", 32'h4417e63a,
            {u_mst.got_q[1].word, u_mst.got_q[0].word})
        rd_chk(16'h0004, 16'h0002, 16'hcccd, 16'h41b4, 16'h0000);
        rd_chk(16'h0005, 16'h0001, 16'h41b4, 16'h0000, 16'h0000);
        // third address of the span is a hole between the floats
        exc_chk(8'h03, 8'h00, 16'h0000, 16'h0006, GSRM_RSP_EXC, 8'h83,
            8'h02, 5);
        exc_chk(8'h03, 8'h00, 16'h1f00, 16'h0001, GSRM_RSP_EXC, 8'h83,
            8'h02, 3);
        exc_chk(8'h03, 8'h00, 16'hffff, 16'h0002, GSRM_RSP_EXC, 8'h83,
            8'h02, 3);
    endtask : t_float

    task automatic t_int();
        logic [15:0] vin [7] = '{16'h0000, 16'h7ffe, 16'h7fff, 16'h8000,
            16'h8001, 16'h8002, 16'hffff};
        logic [15:0] vexp [7] = '{16'h0000, 16'h7ffe, 16'h7ffe, 16'h8002,
            16'h8002, 16'h8002, 16'hffff};
        for (int i = 0; i < 7; i++) begin
            meas.gas_int = vin[i];
            meas.temp_tenths = vin[i];
            rd_chk(16'h0100, 16'h0001, vexp[i], 16'h0000, 16'h0000);
            rd_chk(16'h0102, 16'h0001, vexp[i], 16'h0000, 16'h0000);
        end
    endtask : t_int

    task automatic t_unavail();
        meas.gas_avail = 1'b0;
        meas.temp_avail = 1'b0;
        rd_chk(16'h0000, 16'h0002, 16'h0000, 16'h7fc0, 16'h0000);
        rd_chk(16'h0004, 16'h0002, 16'h0000, 16'h7fc0, 16'h0000);
        rd_chk(16'h0100, 16'h0001, 16'h8000, 16'h0000, 16'h0000);
        rd_chk(16'h0102, 16'h0001, 16'h8000, 16'h0000, 16'h0000);
        meas.gas_avail = 1'b1;
        meas.temp_avail = 1'b1;
        rd_chk(16'h0102, 16'h0001, 16'hffff, 16'h0000, 16'h0000);
    endtask : t_unavail

    task automatic t_status();
        logic [3:0] pat [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h3};
        logic [15:0] gexp [6] = '{16'h0000, 16'h0004, 16'h0008, 16'h0080,
            16'h0100, 16'h0080};
        stat = '0;
        stat.err_code = 32'hdeadbeef;
        rd_chk(16'h0200, 16'h0003, 16'h0000, 16'hbeef, 16'hdead);
        stat.health = 16'h0013;
        rd_chk(16'h0200, 16'h0001, 16'h0013, 16'h0000, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            stat.temp_cond = pat[i];
            stat.gas_cond = pat[i];
            rd_chk(16'h0206, 16'h0002, (gexp[i] == 16'h0100) ? 16'h0000 :
                gexp[i], gexp[i], 16'h0000);
        end
    endtask : t_status

    task automatic t_funcs();
        logic [7:0] fl [4] = '{8'h01, 8'h04, 8'h06, 8'h10};
        exc_chk(8'h2b, 8'h0e, 16'h0000, 16'h0001, GSRM_RSP_IDENT, 8'h2b,
            8'h00, 2);
        exc_chk(8'h2b, 8'h0d, 16'h0000, 16'h0001, GSRM_RSP_EXC, 8'hab,
            8'h01, 2);
        for (int i = 0; i < 4; i++) begin
            exc_chk(fl[i], 8'h00, 16'h0000, 16'h0001, GSRM_RSP_EXC,
                fl[i] | 8'h80, 8'h01, 2);
        end
        exc_chk(8'h03, 8'h00, 16'h0000, 16'h0000, GSRM_RSP_EXC, 8'h83,
            8'h03, 2);
        exc_chk(8'h03, 8'h00, 16'h0000, 16'h007e, GSRM_RSP_EXC, 8'h83,
            8'h03, 2);
    endtask : t_funcs

    task automatic t_snap();
        meas.gas_float = 32'h12345678;
        fork
            u_mst.transact('{8'h03, 8'h00, 16'h0000, 16'h0002});
            begin
                @(u_mst.taken);
                @(negedge ref_clk);
                // a new sample lands the cycle after accept, while the request is still being decoded
                meas.gas_float = 32'h9abcdef0;
            end
        join
        `GSRM_CHK("low", 16'h5678, u_mst.got_q[0].word)
        `GSRM_CHK("high", 16'h1234, u_mst.got_q[1].word)
        rd_chk(16'h0000, 16'h0002, 16'hdef0, 16'h9abc, 16'h0000);
    endtask : t_snap

    initial begin
        srst = 1'b1;
        meas = '0;
        stat = '0;
        repeat (16) @(negedge ref_clk);
        `GSRM_CHK("ready in reset", 1'b0, req_ready)
        `GSRM_CHK("answer in reset", 1'b0, rsp.valid)
        srst = 1'b0;
        t_float();
        t_int();
        t_unavail();
        t_status();
        t_funcs();
        t_snap();
        complete_run();
    end
endmodule : gas_sensor_modbus_register_map_tb_top
